// ---- design/tlw_params.svh ----
// constants for the transmit partitioned line write port
// assumes inclusion by bare name from package and modules
`ifndef TLW_PARAMS_SVH
`define TLW_PARAMS_SVH

// ==========================================================
// geometry
`define TLW_NUM_PARTS      8
`define TLW_PART_SEL_W     3
`define TLW_WORD_W         32
`define TLW_LANE_W         4
`define TLW_PORT_W         8
`define TLW_WORDS_PER_LINE 4
`define TLW_SLOT_W         2
`define TLW_LINES_PER_PART 16
`define TLW_LINE_IDX_W     4

// ==========================================================
// byte-lane patterns: the three legal ones and the all-clear value
`define TLW_LANES_FULL  4'hf
`define TLW_LANES_THREE 4'he
`define TLW_LANES_ONE   4'h8
`define TLW_LANES_NONE  4'h0

// ==========================================================
// reset values and default fill threshold
`define TLW_PTR_RST        4'h0
`define TLW_SLOT_RST       2'h0
`define TLW_FILL_THRESHOLD 5'hc

`endif

// ---- design/tlw_pkg.sv ----
// types shared by both ends of the line write port
// assumes tlw_params.svh is on the include path
`default_nettype none
`include "tlw_params.svh"
package tlw_pkg;
    typedef logic [`TLW_PART_SEL_W-1:0] tlw_part_t;
    typedef logic [`TLW_WORD_W-1:0]     tlw_word_t;
    typedef logic [`TLW_LANE_W-1:0]     tlw_lanes_t;
    typedef logic [`TLW_PORT_W-1:0]     tlw_port_t;
    // one stored word slot: data, lanes, flags, port
    typedef struct packed {
        tlw_word_t  data;
        tlw_lanes_t lanes;
        logic       sop;
        logic       eop;
        logic       err;
        tlw_port_t  port;
    } tlw_slot_t;
    typedef enum logic [2:0] {
        TLW_IDLE  = 3'b001,
        TLW_BURST = 3'b010,
        TLW_GAP   = 3'b100
    } tlw_src_state_t;
endpackage : tlw_pkg
`default_nettype wire

// ---- design/tlw_link_if.sv ----
// signals between application logic and line write port
// assumes one write clock supplied by the application side
`default_nettype none
`include "tlw_params.svh"
interface tlw_link_if (
    input wire logic tx_write_clock  // application write clock
);
    import tlw_pkg::*;
    tlw_part_t  tx_partition_select;
    tlw_word_t  tx_write_word;
    tlw_lanes_t tx_byte_lane_valid;
    logic       tx_packet_start_flag;
    logic       tx_packet_end_flag;
    logic       tx_packet_error_flag;
    logic       tx_write_strobe;
    tlw_port_t  tx_logical_port_number;
    logic       tx_line_terminate;
    logic       tx_buffer_service_disable;
    logic       tx_partition_full;

    modport device (
        input  tx_write_clock, tx_partition_select, tx_write_word, tx_byte_lane_valid,
               tx_packet_start_flag, tx_packet_end_flag, tx_packet_error_flag,
               tx_write_strobe, tx_logical_port_number, tx_line_terminate,
               tx_buffer_service_disable,
        output tx_partition_full
    );
    modport app (
        input  tx_write_clock, tx_partition_full,
        output tx_partition_select, tx_write_word, tx_byte_lane_valid,
               tx_packet_start_flag, tx_packet_end_flag, tx_packet_error_flag,
               tx_write_strobe, tx_logical_port_number, tx_line_terminate,
               tx_buffer_service_disable
    );
endinterface : tlw_link_if
`default_nettype wire

// ---- design/tlw_line_write_port.sv ----
// device end: assembles 32-bit writes into 128-bit partition lines
// assumes sys_clk is the application's write clock, srst synchronous
// assumes the read stub and the writer share that one clock
// limits: no overflow guard; the full flag is the only back-pressure
// What this block does
// - three-bit select, one pointer per partition
// - many logical ports may share one partition
// - four writes fill one line, slot by slot
// - application writes lines as four-word bursts
// - each lane bit qualifies one byte
// - all lanes clear: word dropped, no write
// - lanes all set except on packet's last
// - only 1111, 1110, 1000 are legal; any other nonzero pattern is still written as sent
// - start and end flags active high
// - start flag only on a line's first write
// - end flag accepted on any slot
// - end flag closes line, advances pointer
// - error flag only with end flag
// - capture word only while strobe high
// - logical port stored with each word
// - terminate input advances addressed partition pointer
// - full flag when fill crosses threshold
// - service disable stops reads, writes continue
// - inputs sampled on application write clock
`default_nettype none
`include "tlw_params.svh"
module tlw_line_write_port
    import tlw_pkg::*;
#(
    parameter int          NUM_PARTS  = `TLW_NUM_PARTS,
    parameter int          LINES      = `TLW_LINES_PER_PART,
    parameter logic [4:0]  FILL_LIMIT = `TLW_FILL_THRESHOLD
) (
    input  wire logic      sys_clk,   // write clock from application
    input  wire logic      srst,      // synchronous reset, high
    tlw_link_if.device     link,      // application side
    input  wire logic      rd_pop,    // scheduler consumed one line
    input  wire tlw_part_t rd_part,   // partition being read
    output var  tlw_slot_t rd_slot [`TLW_WORDS_PER_LINE], // line at read pointer
    output logic           rd_valid,  // addressed partition holds a line and service is not disabled
    output logic           service_disabled // read side held idle
);
    localparam int DEPTH = NUM_PARTS * LINES;
    // pointer widths come from the header; LINES must match them, or
    // the pointers wrap early or spill into the next partition's range

    // ======================================================
    // line buffer storage, one array shared by all partitions
    tlw_slot_t tx_line_buffer_ram [DEPTH][`TLW_WORDS_PER_LINE];

    // write side of each partition: line pointer and next word slot
    logic [`TLW_LINE_IDX_W-1:0] wr_ptr_r  [NUM_PARTS];
    logic [`TLW_LINE_IDX_W-1:0] wr_ptr_nxt[NUM_PARTS];
    logic [`TLW_SLOT_W-1:0]     slot_r    [NUM_PARTS];
    logic [`TLW_SLOT_W-1:0]     slot_nxt  [NUM_PARTS];
    // read side of each partition: line pointer and closed-line count
    logic [`TLW_LINE_IDX_W-1:0] rd_ptr_r  [NUM_PARTS];
    logic [`TLW_LINE_IDX_W-1:0] rd_ptr_nxt[NUM_PARTS];
    logic [4:0]                 fill_r    [NUM_PARTS];
    logic [4:0]                 fill_nxt  [NUM_PARTS];
    // status flops behind the two level outputs
    logic                       full_r, full_nxt;
    logic                       dis_r, dis_nxt;
    // write qualification, shared by every partition
    logic                       word_ok;
    logic                       line_done;
    logic                       close_by_end;
    logic                       close_by_slot;
    logic                       close_by_term;
    tlw_part_t                  sel;
    tlw_slot_t                  wr_slot;
    // last word slot of a line; a write here always closes the line
    localparam logic [`TLW_SLOT_W-1:0] LAST_SLOT = 2'h3;

    // ======================================================
    // write qualification
    // the pointer logic is indexed only by the select, so any number of
    // logical ports may land in one partition and share its fifo
    assign sel       = link.tx_partition_select;
    assign word_ok   = link.tx_write_strobe
                     && (link.tx_byte_lane_valid != `TLW_LANES_NONE);
    // a line closes on the fourth slot, on end of packet, or on terminate;
    // the reasons are kept apart so each one can be probed on its own
    assign close_by_end  = word_ok && link.tx_packet_end_flag;
    assign close_by_slot = word_ok && (slot_r[sel] == LAST_SLOT);
    // terminate needs no word: an idle terminate closes a partial line,
    // and one that comes with a word closes the line after that word
    assign close_by_term = link.tx_line_terminate;
    assign line_done     = close_by_end || close_by_slot || close_by_term;

    // ======================================================
    // per-partition pointer and fill bookkeeping
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PARTS; gp++) begin : g_part
            // this partition's own number, sized to compare with a select
            localparam tlw_part_t PART_ID = tlw_part_t'(gp);

            // next pointer, slot and fill of this partition
            always_comb begin
                logic wr_hit;
                logic rd_hit;
                logic wr_here;
                wr_here = word_ok && (sel == PART_ID);
                wr_hit  = line_done && (sel == PART_ID);
                // a pop on an empty partition is ignored, not wrapped
                rd_hit  = rd_pop && !dis_r && (rd_part == PART_ID)
                       && (fill_r[gp] != 5'h0);
                wr_ptr_nxt[gp] = wr_ptr_r[gp];
                slot_nxt[gp]   = slot_r[gp];
                rd_ptr_nxt[gp] = rd_ptr_r[gp];
                fill_nxt[gp]   = fill_r[gp];
                if (wr_hit) begin
                    wr_ptr_nxt[gp] = wr_ptr_r[gp] + 4'h1;
                    slot_nxt[gp]   = `TLW_SLOT_RST;
                end else if (wr_here) begin
                    slot_nxt[gp] = slot_r[gp] + 2'h1;
                end
                if (rd_hit) begin
                    rd_ptr_nxt[gp] = rd_ptr_r[gp] + 4'h1;
                end
                // overflow is the application's concern once full is shown
                fill_nxt[gp] = fill_r[gp] + {4'h0, wr_hit} - {4'h0, rd_hit};
                // reset wins over any write or pop in the same cycle
                if (srst) begin
                    wr_ptr_nxt[gp] = `TLW_PTR_RST;
                    slot_nxt[gp]   = `TLW_SLOT_RST;
                    rd_ptr_nxt[gp] = `TLW_PTR_RST;
                    fill_nxt[gp]   = 5'h0;
                end
            end

            // pointer state of this partition
            always_ff @(posedge sys_clk) begin
                wr_ptr_r[gp] <= wr_ptr_nxt[gp];
                slot_r[gp]   <= slot_nxt[gp];
                rd_ptr_r[gp] <= rd_ptr_nxt[gp];
                fill_r[gp]   <= fill_nxt[gp];
            end
        end
    endgenerate

    // ======================================================
    // ram write: lanes, flags and port kept beside the data
    // the lanes are stored as sent; masking of unused bytes is left to
    // the reader, which needs 1110 and 1000 to place the packet end
    always_comb begin
        wr_slot.data  = link.tx_write_word;
        wr_slot.lanes = link.tx_byte_lane_valid;
        wr_slot.sop   = link.tx_packet_start_flag;
        wr_slot.eop   = link.tx_packet_end_flag;
        wr_slot.err   = link.tx_packet_error_flag;
        wr_slot.port  = link.tx_logical_port_number;
    end

    // one word a cycle at the partition's pointer and slot; a word with
    // no lane set never reaches the array
    always_ff @(posedge sys_clk) begin
        if (word_ok && !srst) begin
            tx_line_buffer_ram[{sel, wr_ptr_r[sel]}][slot_r[sel]] <= wr_slot;
        end
    end

    // ======================================================
    // status: full for the currently selected partition, disable level
    // full follows the select, so a source that switches partitions sees
    // the new partition's state one cycle later; only closed lines count,
    // so a half-built line does not yet push toward the threshold
    always_comb begin
        full_nxt = (fill_nxt[sel] >= FILL_LIMIT);
        // disable only gates the read stub, never the writes
        dis_nxt  = link.tx_buffer_service_disable;
        if (srst) begin
            full_nxt = 1'b0;
            dis_nxt  = 1'b0;
        end
    end

    // status registers, so both level outputs come from flops
    always_ff @(posedge sys_clk) begin
        full_r <= full_nxt;
        dis_r  <= dis_nxt;
    end

    assign link.tx_partition_full = full_r;
    assign service_disabled       = dis_r;

    // ======================================================
    // read view for the downstream scheduler, registered
    // this stub stands in for the line scheduler: it shows the line at the
    // read pointer of rd_part one cycle late and pops one line per rd_pop;
    // while service is disabled it holds rd_valid low and pops nothing
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_valid <= 1'b0;
            for (int i = 0; i < `TLW_WORDS_PER_LINE; i++) begin
                rd_slot[i] <= '0;
            end
        end else begin
            rd_valid <= !dis_r && (fill_nxt[rd_part] != 5'h0);
            for (int i = 0; i < `TLW_WORDS_PER_LINE; i++) begin
                rd_slot[i] <= tx_line_buffer_ram[{rd_part, rd_ptr_nxt[rd_part]}][i];
            end
        end
    end
endmodule : tlw_line_write_port
`default_nettype wire

// ---- design/tlw_line_source.sv ----
// application end: turns packet words into legal line bursts
// assumes same clock as device end, srst synchronous
`default_nettype none
`include "tlw_params.svh"
module tlw_line_source
    import tlw_pkg::*;
(
    input  wire logic       sys_clk,     // application write clock
    input  wire logic       srst,        // synchronous reset, high
    tlw_link_if.app         link,        // device side
    input  wire logic       usr_valid,   // user word offered
    output logic            usr_ready,   // word accepted this cycle
    input  wire tlw_part_t  usr_part,    // target partition
    input  wire tlw_word_t  usr_word,    // data word
    input  wire tlw_lanes_t usr_lanes,   // byte lanes, last word only partial
    input  wire logic       usr_last,    // last word of packet
    input  wire logic       usr_err,     // packet errored
    input  wire tlw_port_t  usr_port,    // logical port
    input  wire logic       usr_terminate, // force line close
    input  wire logic       usr_disable  // hold read service idle
);
    tlw_src_state_t st_r, st_nxt;
    logic [`TLW_SLOT_W-1:0] slot_r, slot_nxt;
    logic                   in_pkt_r, in_pkt_nxt;
    logic                   take;

    // stall while the partition reports full or after a line closes
    assign take      = usr_valid && !link.tx_partition_full && st_r != TLW_GAP;
    assign usr_ready = take;

    // ======================================================
    // burst sequencing
    always_comb begin
        st_nxt     = st_r;
        slot_nxt   = slot_r;
        in_pkt_nxt = in_pkt_r;
        if (take) begin
            in_pkt_nxt = !usr_last;
            if (usr_last || usr_terminate || slot_r == 2'h3) begin
                slot_nxt = `TLW_SLOT_RST;
                st_nxt   = TLW_GAP;
            end else begin
                slot_nxt = slot_r + 2'h1;
                st_nxt   = TLW_BURST;
            end
        end else if (st_r == TLW_GAP) begin
            st_nxt = TLW_IDLE;  // one idle cycle lets full settle
        end else if (usr_terminate && !usr_valid) begin
            slot_nxt = `TLW_SLOT_RST;  // bare terminate closes the open line
        end
        if (srst) begin
            st_nxt     = TLW_IDLE;
            slot_nxt   = `TLW_SLOT_RST;
            in_pkt_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_r     <= st_nxt;
        slot_r   <= slot_nxt;
        in_pkt_r <= in_pkt_nxt;
    end

    // ======================================================
    // registered pin drive
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            link.tx_write_strobe           <= 1'b0;
            link.tx_partition_select       <= '0;
            link.tx_write_word             <= '0;
            link.tx_byte_lane_valid        <= `TLW_LANES_NONE;
            link.tx_packet_start_flag      <= 1'b0;
            link.tx_packet_end_flag        <= 1'b0;
            link.tx_packet_error_flag      <= 1'b0;
            link.tx_logical_port_number    <= '0;
            link.tx_line_terminate         <= 1'b0;
            link.tx_buffer_service_disable <= 1'b0;
        end else begin
            link.tx_write_strobe        <= take;
            link.tx_partition_select    <= usr_part;
            link.tx_write_word          <= usr_word;
            link.tx_byte_lane_valid     <= usr_last ? usr_lanes
                                                    : `TLW_LANES_FULL;
            // start only on the first slot of a line while not in a packet
            link.tx_packet_start_flag   <= take && !in_pkt_r && slot_r == 2'h0;
            link.tx_packet_end_flag     <= take && usr_last;
            link.tx_packet_error_flag   <= take && usr_last && usr_err;
            link.tx_logical_port_number <= usr_port;
            // a stalled word holds terminate back so it is not sent twice
            link.tx_line_terminate      <= usr_terminate && (take || !usr_valid);
            link.tx_buffer_service_disable <= usr_disable;
        end
    end
endmodule : tlw_line_source
`default_nettype wire

// ---- testbench/tlw_link_asserts.sv ----
// checker for the link between the source end and the device end
// assumes it is instantiated beside tlw_link_if, single write clock
`default_nettype none
module tlw_link_asserts
    import tlw_pkg::*;
#(
    parameter logic [4:0] FILL_LIMIT = 5'hc
) (
    input wire logic       tx_write_clock,       // write clock
    input wire logic       srst,                 // sync reset, high
    input wire tlw_part_t  tx_partition_select,  // partition
    input wire tlw_lanes_t tx_byte_lane_valid,   // byte lanes
    input wire logic       tx_packet_start_flag, // packet start
    input wire logic       tx_packet_end_flag,   // packet end
    input wire logic       tx_packet_error_flag, // packet error
    input wire logic       tx_write_strobe,      // word strobe
    input wire logic       tx_line_terminate,    // line close
    input wire logic       tx_partition_full     // full status
);
    default clocking @(posedge tx_write_clock); endclocking
    default disable iff (srst);
    // ==========================================================
    // shadow slot and fill counts; pops are unseen, so fill is an upper bound
    tlw_part_t  sel;
    logic       word;
    logic       close;
    logic [1:0] slot_r [8];
    logic [1:0] slot_nxt [8];
    logic [4:0] fill_r [8];
    logic [4:0] fill_nxt [8];
    logic [4:0] seen_r;
    assign sel = tx_partition_select;
    always_comb begin
        word = tx_write_strobe && (tx_byte_lane_valid != 4'h0);
        close = word && (tx_packet_end_flag || slot_r[sel] == 2'h3);
        slot_nxt = slot_r;
        fill_nxt = fill_r;
        if (close || tx_line_terminate) begin
            slot_nxt[sel] = 2'h0;
            fill_nxt[sel] = (fill_r[sel] == 5'h1f) ? fill_r[sel] : fill_r[sel] + 5'h1;
        end else if (word) begin
            slot_nxt[sel] = slot_r[sel] + 2'h1;
        end
    end
    always_ff @(posedge tx_write_clock) begin
        if (srst) begin
            slot_r <= '{default: 2'h0};
            fill_r <= '{default: 5'h0};
            seen_r <= 5'h0;
        end else begin
            slot_r <= slot_nxt;
            fill_r <= fill_nxt;
            seen_r <= fill_nxt[sel];
        end
    end
    // ==========================================================
    // source side framing and device full status
    chk_err_with_end: assert property (tx_packet_error_flag |-> tx_packet_end_flag && tx_write_strobe)
        else $error("error flag without end flag");
    chk_sop_first_slot: assert property (tx_packet_start_flag |-> word && slot_r[sel] == 2'h0)
        else $error("start flag off the first slot");
    chk_lanes_legal: assert property (tx_write_strobe |-> tx_byte_lane_valid inside {4'hf, 4'he, 4'h8})
        else $error("illegal lane pattern");
    chk_partial_needs_end: assert property (word && tx_byte_lane_valid != 4'hf |-> tx_packet_end_flag)
        else $error("partial word without end flag");
    chk_burst_back: assert property (word && !close && !tx_line_terminate |=> tx_write_strobe)
        else $error("line burst broken");
    chk_close_gap: assert property (close |=> !tx_write_strobe)
        else $error("no idle after closed line");
    chk_full_bound: assert property (tx_partition_full |-> seen_r >= FILL_LIMIT)
        else $error("full below fill threshold");
    chk_reset_quiet: assert property (disable iff (1'b0) srst |=> !tx_partition_full && !tx_write_strobe)
        else $error("link busy after reset");
endmodule : tlw_link_asserts
`default_nettype wire

// ---- testbench/tb_tx_partitioned_line_write_port.sv ----
// testbench: source end feeds device end over the link interface
// assumes 40 MHz sys_clk and the design files compiled first
`default_nettype none
module tb_tx_partitioned_line_write_port;
    timeunit 1ns;
    timeprecision 1ps;
    import tlw_pkg::*;
    logic       sys_clk = 1'b0, srst = 1'b1, rd_pop = 1'b0;
    logic       rd_valid, service_disabled, usr_ready;
    logic       usr_valid = 1'b0, usr_last = 1'b0, usr_err = 1'b0;
    logic       usr_terminate = 1'b0, usr_disable = 1'b0;
    tlw_part_t  rd_part = '0, usr_part = '0;
    tlw_word_t  usr_word = '0;
    tlw_lanes_t usr_lanes = 4'hf;
    tlw_port_t  usr_port = '0;
    tlw_slot_t  rd_slot [4];
    int         err_count = 0, samples_checked = 0;
    // ==========================================================
    // both ends joined by one interface, checker beside it
    tlw_link_if tlw_link_if_inst (.tx_write_clock(sys_clk));
    tlw_line_write_port tlw_line_write_port_inst (.sys_clk(sys_clk), .srst(srst), .link(tlw_link_if_inst),
        .rd_pop(rd_pop), .rd_part(rd_part), .rd_slot(rd_slot), .rd_valid(rd_valid),
        .service_disabled(service_disabled));
    tlw_line_source tlw_line_source_inst (.sys_clk(sys_clk), .srst(srst), .link(tlw_link_if_inst),
        .usr_valid(usr_valid), .usr_ready(usr_ready), .usr_part(usr_part), .usr_word(usr_word),
        .usr_lanes(usr_lanes), .usr_last(usr_last), .usr_err(usr_err), .usr_port(usr_port),
        .usr_terminate(usr_terminate), .usr_disable(usr_disable));
    tlw_link_asserts #(.FILL_LIMIT(5'hc)) tlw_link_asserts_inst (.tx_write_clock(sys_clk), .srst(srst),
        .tx_partition_select(tlw_link_if_inst.tx_partition_select),
        .tx_byte_lane_valid(tlw_link_if_inst.tx_byte_lane_valid),
        .tx_packet_start_flag(tlw_link_if_inst.tx_packet_start_flag),
        .tx_packet_end_flag(tlw_link_if_inst.tx_packet_end_flag),
        .tx_packet_error_flag(tlw_link_if_inst.tx_packet_error_flag),
        .tx_write_strobe(tlw_link_if_inst.tx_write_strobe),
        .tx_line_terminate(tlw_link_if_inst.tx_line_terminate),
        .tx_partition_full(tlw_link_if_inst.tx_partition_full));
    initial forever #12.5 sys_clk = ~sys_clk;
    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic tlw_word_t word_of(input tlw_part_t p, input tlw_port_t pt, input int k);
        return {4'ha, 1'b0, p, pt, 8'h00, 8'(k)};
    endfunction : word_of
    // holds valid up afterwards so back-to-back words need no gap
    task automatic send(input tlw_part_t p, input int k, input tlw_lanes_t l, input logic last,
                        input logic er, input tlw_port_t pt, input logic term);
        int   n;
        logic ok;
        n = 0;
        ok = 1'b0;
        usr_valid = 1'b1;
        usr_part = p;
        usr_word = word_of(p, pt, k);
        usr_lanes = l;
        usr_last = last;
        usr_err = er;
        usr_port = pt;
        usr_terminate = term;
        // hold the word until an edge samples ready high
        while (!ok && n < 50) begin
            @(posedge sys_clk);
            ok = usr_ready;
            n++;
        end
        if (!ok) err_count++;
        #1;
    endtask : send
    task automatic idle;
        usr_valid = 1'b0;
        usr_terminate = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask : idle
    task automatic packet(input tlw_part_t p, input tlw_port_t pt, input int n, input tlw_lanes_t l,
                          input logic er);
        for (int i = 0; i < n; i++) send(p, i, (i == n - 1) ? l : 4'hf, i == n - 1, er && i == n - 1, pt, 1'b0);
        idle;
    endtask : packet
    task automatic look(input tlw_part_t p);
        rd_part = p;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : look
    task automatic pop;
        rd_pop = 1'b1;
        @(posedge sys_clk);
        #1;
        rd_pop = 1'b0;
    endtask : pop
    task automatic slot(input int i, input tlw_part_t p, input tlw_port_t pt, input tlw_lanes_t l,
                        input logic [2:0] flags);
        check(rd_slot[i].data, word_of(p, pt, i));
        check(rd_slot[i].lanes, l);
        check({rd_slot[i].sop, rd_slot[i].eop, rd_slot[i].err}, flags);
        check(rd_slot[i].port, pt);
    endtask : slot
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    // ==========================================================
    // hang guard, well above the under two hundred cycles the tests take
    initial begin
        #100us;
        err_count++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        // four-word line lands in four slots of partition 3
        packet(3'h3, 8'h5a, 4, 4'hf, 1'b0);
        look(3'h3);
        check(rd_valid, 1'b1);
        for (int i = 0; i < 4; i++) slot(i, 3'h3, 8'h5a, 4'hf, {i == 0, i == 3, 1'b0});
        pop;
        $display("test full_line done");
        // early end with error, then a second port on the same partition
        packet(3'h5, 8'h11, 2, 4'he, 1'b1);
        packet(3'h5, 8'h22, 1, 4'h8, 1'b0);
        look(3'h5);
        slot(0, 3'h5, 8'h11, 4'hf, 3'b100);
        slot(1, 3'h5, 8'h11, 4'he, 3'b011);
        pop;
        look(3'h5);
        slot(0, 3'h5, 8'h22, 4'h8, 3'b110);
        pop;
        look(3'h5);
        check(rd_valid, 1'b0);
        $display("test early_end done");
        // terminate closes a one-word line
        send(3'h6, 0, 4'hf, 1'b0, 1'b0, 8'h33, 1'b1);
        idle;
        look(3'h6);
        check(rd_valid, 1'b1);
        slot(0, 3'h6, 8'h33, 4'hf, 3'b100);
        pop;
        $display("test terminate done");
        // reads held off, writes fill partition 1 to the threshold
        usr_disable = 1'b1;
        for (int k = 0; k < 12; k++) begin
            packet(3'h1, 8'h44, 4, 4'hf, 1'b0);
            if (k == 10) check(tlw_link_if_inst.tx_partition_full, 1'b0);
        end
        check(tlw_link_if_inst.tx_partition_full, 1'b1);
        check(service_disabled, 1'b1);
        look(3'h1);
        check(rd_valid, 1'b0);
        $display("test fill_full done");
        // mid-run reset empties every partition
        srst = 1'b1;
        usr_disable = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        look(3'h1);
        check(rd_valid, 1'b0);
        check(tlw_link_if_inst.tx_partition_full, 1'b0);
        $display("test reset done");
        tally_and_finish;
    end
endmodule : tb_tx_partitioned_line_write_port
`default_nettype wire
